// ### rtl/rbc_params.svh
// Constants for the relay bank controller: command codes, register
// offsets, field positions, reset values and timing counts.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef RBC_PARAMS_SVH
`define RBC_PARAMS_SVH

`define RBC_CLK_HZ          20000000
`define RBC_HOLD_MS         50
`define RBC_PULSE_PERIOD_US 1000
`define RBC_HOLD_CYC        ((`RBC_CLK_HZ / 1000) * `RBC_HOLD_MS)
`define RBC_HALF_CYC        ((`RBC_CLK_HZ / 1000000) * `RBC_PULSE_PERIOD_US / 2)
`define RBC_INIT_US         100
`define RBC_INIT_CYC        ((`RBC_CLK_HZ / 1000000) * `RBC_INIT_US)

`define RBC_NUM_RELAYS      6

`define RBC_ADDR_CMD        4'h0
`define RBC_ADDR_RELAY      4'h1
`define RBC_ADDR_SAVER      4'h2
`define RBC_ADDR_STATUS     4'h3
`define RBC_ADDR_DRIVE      4'h4
`define RBC_ADDR_LINK       4'h5

`define RBC_CMD_OP_LSB      8
`define RBC_CMD_OP_MSB      9
`define RBC_CMD_IDX_LSB     4
`define RBC_CMD_IDX_MSB     6
`define RBC_CMD_VAL_BIT     0
`define RBC_CMD_MASK_LSB    0
`define RBC_CMD_MASK_MSB    5

`define RBC_OP_SINGLE       2'h1
`define RBC_OP_ALL          2'h2
`define RBC_OP_SAVER        2'h3

`define RBC_ST_OK           8'h00
`define RBC_ST_BAD_INDEX    8'h01
`define RBC_ST_BAD_OP       8'h02
`define RBC_ST_NONE         8'h80

`define RBC_LINK_BUSY_BIT   0
`define RBC_LINK_INIT_BIT   1

`endif

// ### rtl/rbc_pkg.sv
// Types shared by the relay bank controller files.
// Constants live in rbc_params.svh.
package rbc_pkg;

   typedef logic [5:0] rbc_mask_t;

   typedef struct packed {
      logic [1:0] op;
      logic [2:0] index;
      logic       value;
      rbc_mask_t  mask;
   } rbc_cmd_s;

   typedef enum logic [1:0] {
      RBC_CH_OFF,
      RBC_CH_HOLD,
      RBC_CH_PULSE
   } rbc_ch_e;

endpackage

// ### rtl/rbc_channel.sv
// One relay output channel: full-on hold, then pulsed power-save drive.
// Assumes half_tick_i is a one-cycle enable every half pulse period.
`timescale 1ns/1ps
`include "rbc_params.svh"

module rbc_channel #(
   parameter int HOLD_CYC = `RBC_HOLD_CYC
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   input  wire logic energize_i,
   input  wire logic saver_i,
   input  wire logic half_tick_i,
   output logic      drive_o
);

   localparam int CW = $clog2(HOLD_CYC + 1);

   rbc_pkg::rbc_ch_e state;
   rbc_pkg::rbc_ch_e next_state;
   logic [CW-1:0]    hold_cnt;
   logic             phase;
   logic             next_drive;
   wire              hold_done = (hold_cnt == CW'(HOLD_CYC - 1));

   always_comb begin
      next_state = state;
      case (state)
         rbc_pkg::RBC_CH_OFF:
            if (energize_i) next_state = rbc_pkg::RBC_CH_HOLD;
         rbc_pkg::RBC_CH_HOLD:
            if (!energize_i) next_state = rbc_pkg::RBC_CH_OFF;
            else if (saver_i && hold_done)
               next_state = rbc_pkg::RBC_CH_PULSE;
         rbc_pkg::RBC_CH_PULSE:
            if (!energize_i) next_state = rbc_pkg::RBC_CH_OFF;
            else if (!saver_i) next_state = rbc_pkg::RBC_CH_HOLD;
         default: next_state = rbc_pkg::RBC_CH_OFF;
      endcase
   end

   // Pulsed phase starts with the coil off until the next shared half tick
   assign next_drive = (next_state == rbc_pkg::RBC_CH_HOLD) ||
                       ((next_state == rbc_pkg::RBC_CH_PULSE) &&
                        (state == rbc_pkg::RBC_CH_PULSE) &&
                        (half_tick_i ? !phase : phase));

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state    <= rbc_pkg::RBC_CH_OFF;
         hold_cnt <= '0;
         phase    <= 1'b0;
         drive_o  <= 1'b0;
      end else begin
         state    <= next_state;
         drive_o  <= next_drive;
         phase    <= (next_state == rbc_pkg::RBC_CH_PULSE) ? next_drive
                                                          : 1'b0;
         if (state != rbc_pkg::RBC_CH_HOLD)
            hold_cnt <= '0;
         else if (!hold_done)
            hold_cnt <= hold_cnt + CW'(1);
      end
   end

endmodule // rbc_channel

// ### rtl/rbc_top.sv
// Relay bank controller: command decode, relay state, power-save masks,
// link and relay indicators, status of the previous command.
// Assumes a link receiver on the same clock delivering commands as
// register writes and a busy level while a transfer is received.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "rbc_params.svh"

// How it works
// - Link indicator lit from reset until the init counter expires.
// - After init, link indicator follows the transfer-in-progress level.
// - Relay indicator lit exactly while its relay is energized.
// - Power-save relay: 50 ms full on, then 1 ms square wave, 50%.
// - Single command carries index 0-5; only that relay changes.
// - State 0 de-energizes (common to NC), 1 energizes (common to NO).
// - All-relays mask bit n sets relay n, same meaning as single.
// - All-relays mask applied to six relays in one cycle.
// - Status read reports the outcome of the previous command.
// - Power-save mask bit n: 1 pulsed mode, 0 continuous drive.
// - After reset no relay pulses until a power-save command.
module rbc_top #(
   parameter int NUM_RELAYS = `RBC_NUM_RELAYS,
   parameter int HOLD_CYC   = `RBC_HOLD_CYC,
   parameter int HALF_CYC   = `RBC_HALF_CYC,
   parameter int INIT_CYC   = `RBC_INIT_CYC
) (
   input  wire logic                  ref_clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic [3:0]            addr_i,
   input  wire logic [15:0]           wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [15:0]           rdata_o,
   input  wire logic                  link_rx_busy_i,
   output logic                       link_indicator_o,
   output logic      [NUM_RELAYS-1:0] relay_drive_o,
   output logic      [NUM_RELAYS-1:0] relay_indicators_o
);

   localparam int IW = $clog2(INIT_CYC + 1);
   localparam int HW = $clog2(HALF_CYC + 1);

   function automatic logic [7:0] rbc_outcome(input rbc_pkg::rbc_cmd_s c);
      if (c.op == `RBC_OP_SINGLE && c.index >= 3'(NUM_RELAYS))
         rbc_outcome = `RBC_ST_BAD_INDEX;
      else if (c.op == 2'h0)
         rbc_outcome = `RBC_ST_BAD_OP;
      else
         rbc_outcome = `RBC_ST_OK;
   endfunction

   rbc_pkg::rbc_cmd_s     cmd;
   logic [NUM_RELAYS-1:0] relay_state;
   logic [NUM_RELAYS-1:0] saver_mask;
   logic [NUM_RELAYS-1:0] next_relay_state;
   logic [NUM_RELAYS-1:0] next_saver_mask;
   logic [7:0]            status;
   logic [7:0]            last_outcome;
   logic [IW-1:0]         init_cnt;
   logic                  init_done;
   logic [HW-1:0]         half_cnt;
   logic                  half_tick;
   logic [15:0]           next_rdata;

   wire cmd_wr    = wr_i && (addr_i == `RBC_ADDR_CMD);
   wire relay_wr  = wr_i && (addr_i == `RBC_ADDR_RELAY);
   wire saver_wr  = wr_i && (addr_i == `RBC_ADDR_SAVER);
   wire op_single = cmd_wr && (cmd.op == `RBC_OP_SINGLE);
   wire op_all    = (cmd_wr && (cmd.op == `RBC_OP_ALL)) || relay_wr;
   wire op_saver  = (cmd_wr && (cmd.op == `RBC_OP_SAVER)) || saver_wr;
   wire idx_ok    = (cmd.index < 3'(NUM_RELAYS));

   assign cmd.op    = wdata_i[`RBC_CMD_OP_MSB:`RBC_CMD_OP_LSB];
   assign cmd.index = wdata_i[`RBC_CMD_IDX_MSB:`RBC_CMD_IDX_LSB];
   assign cmd.value = wdata_i[`RBC_CMD_VAL_BIT];
   assign cmd.mask  = wdata_i[`RBC_CMD_MASK_MSB:`RBC_CMD_MASK_LSB];

   always_comb begin
      next_relay_state = relay_state;
      if (op_all)
         next_relay_state = cmd.mask[NUM_RELAYS-1:0];
      else if (op_single && idx_ok)
         next_relay_state[cmd.index] = cmd.value;
   end

   assign next_saver_mask = op_saver ? cmd.mask[NUM_RELAYS-1:0]
                                     : saver_mask;

   always_comb begin
      case (addr_i)
         `RBC_ADDR_RELAY:  next_rdata = 16'(relay_state);
         `RBC_ADDR_SAVER:  next_rdata = 16'(saver_mask);
         `RBC_ADDR_STATUS: next_rdata = {8'h00, status};
         `RBC_ADDR_DRIVE:  next_rdata = 16'(relay_drive_o);
         `RBC_ADDR_LINK:   next_rdata = {14'h0000, init_done,
                                         link_rx_busy_i};
         default:          next_rdata = 16'h0000;
      endcase
   end

   // Outcome shows only once the next command arrives
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         relay_state  <= '0;
         saver_mask   <= '0;
         status       <= `RBC_ST_NONE;
         last_outcome <= `RBC_ST_NONE;
      end else begin
         relay_state <= next_relay_state;
         saver_mask  <= next_saver_mask;
         if (cmd_wr) begin
            status       <= last_outcome;
            last_outcome <= rbc_outcome(cmd);
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         rdata_o <= 16'h0000;
      else if (rd_i)
         rdata_o <= next_rdata;
      else
         rdata_o <= 16'h0000;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         init_cnt  <= '0;
         init_done <= 1'b0;
      end else if (!init_done) begin
         init_cnt  <= init_cnt + IW'(1);
         init_done <= (init_cnt == IW'(INIT_CYC - 1));
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         link_indicator_o <= 1'b1;
      else
         link_indicator_o <= !init_done || link_rx_busy_i;
   end

   // Shared half-period tick; pulse edges of channels stay aligned
   assign half_tick = (half_cnt == HW'(HALF_CYC - 1));

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         half_cnt <= '0;
      else
         half_cnt <= half_tick ? '0 : half_cnt + HW'(1);
   end

   for (genvar n = 0; n < NUM_RELAYS; n++) begin : g_ch
      rbc_channel #(
         .HOLD_CYC (HOLD_CYC)
      ) u_ch (
         .ref_clk_i   (ref_clk_i),
         .rst_n_i     (rst_n_i),
         .energize_i  (relay_state[n]),
         .saver_i     (saver_mask[n]),
         .half_tick_i (half_tick),
         .drive_o     (relay_drive_o[n])
      );
   end

   // Commanded state, not pulsed drive, so LEDs stay steady
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         relay_indicators_o <= '0;
      else
         relay_indicators_o <= relay_state;
   end

endmodule // rbc_top

// ### tb/rbc_checker.sv
// Port assertions for the relay bank controller.
// Assumes one clock; bound into rbc_top below.
`timescale 1ns/1ps
module rbc_checker #(
   parameter int NUM_RELAYS = 6,
   parameter int HOLD_CYC   = 40,
   parameter int HALF_CYC   = 4,
   parameter int INIT_CYC   = 5
) (
   input wire logic                  ref_clk_i,
   input wire logic                  rst_n_i,
   input wire logic [3:0]            addr_i,
   input wire logic [15:0]           wdata_i,
   input wire logic                  wr_i,
   input wire logic                  link_rx_busy_i,
   input wire logic                  link_indicator_o,
   input wire logic [NUM_RELAYS-1:0] relay_drive_o,
   input wire logic [NUM_RELAYS-1:0] relay_indicators_o
);
   // Wide enough for the full init count, not only the short bench one
   logic [31:0]      up;
   logic [31:0]      on_cnt;
   logic             seen;
   wire  logic [1:0] op  = wdata_i[9:8];
   wire  logic       cmd = wr_i && addr_i == 4'h0;
   wire  logic       one = cmd && op == 2'h1;
   wire  logic       all = wr_i && (addr_i == 4'h1 || cmd && op == 2'h2);
   wire  logic       sav = wr_i && (addr_i == 4'h2 || cmd && op == 2'h3);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Run length of relay 0 drive, judged when it drops
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
      if (!rst_n_i) begin
         up <= 32'h0;
         on_cnt <= 32'h0;
         seen <= 1'b0;
      end else begin
         up <= up + {31'h0, up != 32'hFFFF_FFFF};
         on_cnt <= relay_drive_o[0] ? on_cnt + 32'h1 : 32'h0;
         seen <= seen | sav;
      end
   property p_init; up < INIT_CYC |-> link_indicator_o; endproperty
   a_init: assert property (p_init) else $error("lamp dark in init");
   property p_busy;
      up > INIT_CYC + 2 |-> link_indicator_o == $past(link_rx_busy_i);
   endproperty
   a_busy: assert property (p_busy) else $error("lamp not busy");
   property p_lit; (relay_drive_o & ~relay_indicators_o) == '0; endproperty
   a_lit: assert property (p_lit) else $error("drive without lamp");
   property p_new;
      (relay_indicators_o & ~$past(relay_indicators_o) & ~relay_drive_o) == '0;
   endproperty
   a_new: assert property (p_new) else $error("no full-on start");
   property p_all;
      all |-> ##2 relay_indicators_o == $past(wdata_i[NUM_RELAYS-1:0], 2);
   endproperty
   a_all: assert property (p_all) else $error("mask not applied");
   property p_bad; one && wdata_i[6:4] > 3'h5 |-> ##2 $stable(relay_indicators_o);
   endproperty
   a_bad: assert property (p_bad) else $error("bad index acted");
   property p_one;
      one && wdata_i[6:4] < 3'h6 |-> ##2
         relay_indicators_o[$past(wdata_i[6:4], 2)] == $past(wdata_i[0], 2);
   endproperty
   a_one: assert property (p_one) else $error("relay not set");
   property p_steady; !seen |-> relay_drive_o == relay_indicators_o; endproperty
   a_steady: assert property (p_steady) else $error("early pulse");
   property p_hold;
      $fell(relay_drive_o[0]) && relay_indicators_o[0] |->
         on_cnt == HOLD_CYC || on_cnt == HALF_CYC;
   endproperty
   a_hold: assert property (p_hold) else $error("bad on time");
   c_pulse: cover property ($fell(relay_drive_o[0]) && relay_indicators_o[0]);
   c_bad: cover property (one && wdata_i[6:4] > 3'h5);
   c_all: cover property (all);
endmodule // rbc_checker

bind rbc_top rbc_checker #(.NUM_RELAYS(NUM_RELAYS), .HOLD_CYC(HOLD_CYC),
   .HALF_CYC(HALF_CYC), .INIT_CYC(INIT_CYC)) rbc_checker_inst (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .link_rx_busy_i(link_rx_busy_i),
   .link_indicator_o(link_indicator_o), .relay_drive_o(relay_drive_o),
   .relay_indicators_o(relay_indicators_o));

// ### tb/rbc_link_master.sv
// Remote master model: random link frames on the busy level.
// Assumes the bench seeds the generator before enabling it.
`timescale 1ns/1ps
module rbc_link_master (
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   input  wire logic en_i,
   output logic      link_rx_busy_o
);
   initial begin
      link_rx_busy_o = 1'b0;
      forever begin
         @(posedge ref_clk_i iff (rst_n_i && en_i));
         repeat ($urandom_range(8, 2)) @(posedge ref_clk_i);
         link_rx_busy_o <= 1'b1;
         repeat ($urandom_range(8, 2)) @(posedge ref_clk_i);
         link_rx_busy_o <= 1'b0;
      end
   end
endmodule // rbc_link_master

// ### tb/tb.sv
// Self-checking bench: register master in front, link master behind.
// Assumes short hold, pulse and init counts to keep the run brief.
`timescale 1ns/1ps
module tb;
   localparam int HOLD = 40;
   localparam int HALF = 4;
   localparam int INIT = 5;
   logic        ref_clk_i, rst_n_i, wr_i, rd_i, busy, lamp, en;
   logic        rd_d = 1'b0;
   logic [3:0]  addr_i;
   logic [15:0] wdata_i, rdata_o, exp_q[$];
   logic [5:0]  drive, ind, m;
   logic [7:0]  st, pend;
   int          failures, cmp_count, cyc, n;
   rbc_top #(.HOLD_CYC(HOLD), .HALF_CYC(HALF), .INIT_CYC(INIT))
   rbc_top_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .link_rx_busy_i(busy), .link_indicator_o(lamp),
      .relay_drive_o(drive), .relay_indicators_o(ind));
   rbc_link_master rbc_link_master_inst (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .en_i(en), .link_rx_busy_o(busy));
   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   task automatic give_verdict();
      $display("compares %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
      if (!w) exp_q.push_back(d);
      @(posedge ref_clk_i);
   endtask
   task automatic idle(input int c);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (c) @(posedge ref_clk_i);
   endtask
   // Status answers one command late
   task automatic cmd(input logic [15:0] d, input logic [7:0] o);
      bus(1'b1, 4'h0, d);
      st = pend;
      pend = o;
   endtask
   task automatic one(input logic [2:0] i, input logic b);
      cmd({8'h01, 1'b0, i, 3'h0, b}, (i > 3'h5) ? 8'h01 : 8'h00);
   endtask
   task automatic lows(input int c);
      n = 0;
      repeat (c) begin
         @(posedge ref_clk_i);
         n += int'(drive[0] === 1'b0);
      end
   endtask
   always @(posedge ref_clk_i) begin
      if (rd_d === 1'b1 && exp_q.size() > 0) chk(rdata_o, exp_q.pop_front());
      rd_d <= rd_i;
      cyc++;
      if (cyc == 2000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(32'h4748));
      {rst_n_i, wr_i, rd_i, en} = 4'h0;
      addr_i = 4'h0;
      wdata_i = 16'h0000;
      {st, pend} = 16'h8080;
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      chk(lamp, 1'b1);
      idle(INIT + 2);
      chk(lamp, 1'b0);
      bus(1'b0, 4'h5, 16'h0002);
      en <= 1'b1;
      bus(1'b0, 4'h3, 16'h0080);
      for (int i = 0; i < 8; i++) begin
         if (i < 6) m[i] = 1'($urandom);
         // Bad indices carry the inverse, so a wrong update shows
         one(i[2:0], (i < 6) ? m[i % 6] : !m[i % 6]);
         bus(1'b0, 4'h3, {8'h00, st});
      end
      idle(2);
      chk(16'(ind), 16'(m));
      chk(16'(drive), 16'(m));
      cmd(16'h0005, 8'h02);
      m = 6'($urandom);
      cmd({8'h02, 2'h0, m}, 8'h00);
      bus(1'b0, 4'h3, {8'h00, st});
      bus(1'b0, 4'h1, {10'h000, m});
      bus(1'b0, 4'h4, {10'h000, m});
      bus(1'b0, 4'hF, 16'h0000);
      idle(1);
      chk(ind, m);
      @(posedge ref_clk_i iff busy === 1'b1);
      @(posedge ref_clk_i);
      chk(lamp, 1'b1);
      bus(1'b1, 4'h1, 16'h0000);
      cmd(16'h0301, 8'h00);
      bus(1'b0, 4'h2, 16'h0001);
      one(3'h0, 1'b1);
      idle(HOLD + 2 * HALF);
      lows(8 * HALF);
      chk(16'(n), 16'(4 * HALF));
      chk(ind[0], 1'b1);
      one(3'h0, 1'b0);
      one(3'h0, 1'b1);
      idle(1);
      lows(HOLD - 4);
      chk(16'(n), 16'h0000);
      bus(1'b1, 4'h2, 16'h0000);
      idle(2 * HALF);
      lows(8 * HALF);
      chk(16'(n), 16'h0000);
      bus(1'b0, 4'h3, {8'h00, st});
      idle(2);
      give_verdict();
   end
endmodule // tb
